// *** hw/wuo_edge_det.v ***
// Per-pin edge detector with both-edge or single-edge selection for the wake-up inputs
`include "wuo_regs.vh"

module wuo_edge_det #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             clock_in,
  input  wire             rstn_in,
  // Pin levels and trigger selection
  input  wire [WIDTH-1:0] level_in,
  input  wire [WIDTH-1:0] mode_in,
  input  wire [WIDTH-1:0] edge_in,
  // Edge hits, one-cycle pulses
  output wire [WIDTH-1:0] hit_out,
  output wire [WIDTH-1:0] rise_out,
  output wire [WIDTH-1:0] fall_out
);

  reg [WIDTH-1:0] prev_ff;
  reg             armed_ff;

  // ----------------------------------------------------------------
  // Previous level; no edge is reported on the first cycle after reset
  // ----------------------------------------------------------------
  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prev_ff  <= {WIDTH{1'b0}};
      armed_ff <= 1'b0;
    end else begin
      prev_ff  <= level_in;
      armed_ff <= 1'b1;
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
      wire rise;
      wire fall;
      assign rise        = armed_ff & level_in[i] & ~prev_ff[i];
      assign fall        = armed_ff & ~level_in[i] & prev_ff[i];
      assign rise_out[i] = rise;
      assign fall_out[i] = fall;
      // Mode 0 takes both edges and ignores the polarity bit
      assign hit_out[i]  = mode_in[i] ? (edge_in[i] ? rise : fall)
                                      : (rise | fall); // [RULE2] [RULE9] [RULE10] [RULE11]
    end
  endgenerate

endmodule

// *** hw/wuo_onoff.v ***
// Wake-up on/off interrupt logic: eight edge-selectable wake inputs merged into interrupt 0
//
// Operation
// (RULE1) Eight wake inputs on the port pins; any may release standby.
// (RULE2) Each input picks both edges, rising only or falling only.
// (RULE3) Per-input enable bit: 0 blocks the input, 1 passes it.
// (RULE4) Any wake request raises the shared interrupt 0 request.
// (RULE5) Interrupt 0 from wake logic is still gated by priority and mask.
// (RULE6) Any enable bit set: interrupt 0 uses wake mode, ignores its pin.
// (RULE7) Software writes enable register to zero to use the dedicated pin.
// (RULE8) Flag register reads 1 per input with a pending request.
// (RULE9) Mode bit 0 triggers on both edges, 1 on one edge.
// (RULE10) In single-edge mode polarity bit 0 is falling, 1 rising.
// (RULE11) Mode bit 0 ignores the polarity bit and takes both edges.
// (RULE12) Detectors sample the real pin level whatever the pin function.
// (RULE13) Pins with dedicated and wake interrupts raise both when enabled.
// (RULE14) Reset clears all four wake registers to zero.
// (RULE15) Interrupt mask bits reset to 1; writing 0 blocks the source.
// (RULE16) Selected edge on enabled input sets its flag; writing 0 clears.
// (RULE17) Software masks, configures, clears request, waits three cycles, unmasks.
//
// The implementer's own choice: the address-and-strobe port.
`include "wuo_regs.vh"

module wuo_onoff #(
  parameter NUM_WAKE = 8
) (
  // Clock and reset
  input  wire                     clock_in,
  input  wire                     rstn_in,
  // Register port
  input  wire [`WUO_ADDR_W-1:0]   reg_addr_in,
  input  wire [`WUO_DATA_W-1:0]   reg_wdata_in,
  input  wire                     reg_wr_in,
  input  wire                     reg_rd_in,
  output wire [`WUO_DATA_W-1:0]   reg_rdata_out,
  // Port pins and dedicated interrupt 0 pin
  input  wire [NUM_WAKE-1:0]      wake_pin_in,
  input  wire                     ext_irq_zero_pin_in,
  // Interrupt requests towards the interrupt controller
  output wire                     shared_ext_irq_zero_out,
  output wire [`WUO_PRIO_W-1:0]   irq_zero_level_out,
  output wire                     dedicated_ext_irq_five_out,
  output wire                     dedicated_ext_irq_six_out,
  output wire                     dedicated_ext_irq_seven_out,
  // Standby release and status
  output wire                     standby_release_out,
  output wire                     wake_mode_active_out,
  output wire                     irq_out
);

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  reg rst_meta_ff;
  reg rst_sync_ff;

  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  wire rstn_sync;
  assign rstn_sync = rst_sync_ff;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [NUM_WAKE-1:0]     wake_flag_bits_ff;
  reg [NUM_WAKE-1:0]     wake_mode_bits_ff;
  reg [NUM_WAKE-1:0]     wake_edge_bits_ff;
  reg [NUM_WAKE-1:0]     wake_enable_bits_ff;
  reg [`WUO_DATA_W-1:0]  irq_mask_group_zero_ff;
  reg [`WUO_PRIO_W-1:0]  irq_priority_zero_ff;
  reg                    irq_zero_pend_ff;
  reg [`WUO_EVT_W-1:0]   evt_status_ff;
  reg [`WUO_EVT_W-1:0]   evt_mask_ff;
  reg [`WUO_DATA_W-1:0]  rdata_ff;
  reg                    irq_zero_out_ff;
  reg [`WUO_PRIO_W-1:0]  level_out_ff;
  reg                    ded_five_ff;
  reg                    ded_six_ff;
  reg                    ded_seven_ff;
  reg                    standby_ff;
  reg                    wake_mode_ff;
  reg                    irq_ff;
  reg                    ext_prev_ff;
  reg                    ext_armed_ff;

  reg [NUM_WAKE-1:0]     nxt_wake_flag_bits;
  reg                    nxt_irq_zero_pend;
  reg [`WUO_EVT_W-1:0]   nxt_evt_status;
  reg [`WUO_DATA_W-1:0]  nxt_rdata;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire wr_flags;
  wire wr_mode;
  wire wr_edge;
  wire wr_enable;
  wire wr_mask0;
  wire wr_prio;
  wire wr_clear;
  wire wr_evt_mask;
  wire rd_evt_status;

  assign wr_flags      = reg_wr_in & (reg_addr_in == `WUO_OFS_WAKE_FLAGS);
  assign wr_mode       = reg_wr_in & (reg_addr_in == `WUO_OFS_WAKE_MODE);
  assign wr_edge       = reg_wr_in & (reg_addr_in == `WUO_OFS_WAKE_EDGE);
  assign wr_enable     = reg_wr_in & (reg_addr_in == `WUO_OFS_WAKE_ENABLE);
  assign wr_mask0      = reg_wr_in & (reg_addr_in == `WUO_OFS_IRQ_MASK0);
  assign wr_prio       = reg_wr_in & (reg_addr_in == `WUO_OFS_IRQ_PRIO0);
  assign wr_clear      = reg_wr_in & (reg_addr_in == `WUO_OFS_IRQ_CLEAR);
  assign wr_evt_mask   = reg_wr_in & (reg_addr_in == `WUO_OFS_EVT_MASK);
  assign rd_evt_status = reg_rd_in & (reg_addr_in == `WUO_OFS_EVT_STATUS);

  // ----------------------------------------------------------------
  // Edge detection on the raw pin levels
  // ----------------------------------------------------------------
  // Pins are read whatever their port function, so an output pin toggled
  // by firmware can wake the part too.
  wire [NUM_WAKE-1:0] wake_hit;
  wire [NUM_WAKE-1:0] pin_rise;

  wuo_edge_det #(
    .WIDTH    (NUM_WAKE)
  ) u_edge (
    .clock_in (clock_in),
    .rstn_in  (rstn_sync),
    .level_in (wake_pin_in),          // [RULE12]
    .mode_in  (wake_mode_bits_ff),
    .edge_in  (wake_edge_bits_ff),
    .hit_out  (wake_hit),
    .rise_out (pin_rise),
    .fall_out ()
  );

  wire [NUM_WAKE-1:0] wake_set;
  wire                wake_any_set;
  wire                wake_mode;
  wire                ext_rise;

  assign wake_set     = wake_hit & wake_enable_bits_ff;    // [RULE3] [RULE16]
  assign wake_any_set = |wake_set;                         // [RULE1] [RULE4]
  assign wake_mode    = |wake_enable_bits_ff;              // [RULE6]
  // A pin that is already high when reset lifts is not taken as an edge;
  // the wake detector arms itself the same way.
  assign ext_rise     = ext_armed_ff & ext_irq_zero_pin_in & ~ext_prev_ff;

  // ----------------------------------------------------------------
  // Dedicated interrupts on the shared pins
  // ----------------------------------------------------------------
  // These run beside the wake path, so one edge can raise both requests.
  wire ded_five;
  wire ded_six;
  wire ded_seven;
  wire ded_hit_any;

  assign ded_five    = pin_rise[`WUO_PIN_IRQ5] & irq_mask_group_zero_ff[`WUO_MASK0_IRQ5_BIT];
  assign ded_six     = pin_rise[`WUO_PIN_IRQ6] & irq_mask_group_zero_ff[`WUO_MASK0_IRQ6_BIT];
  assign ded_seven   = pin_rise[`WUO_PIN_IRQ7] & irq_mask_group_zero_ff[`WUO_MASK0_IRQ7_BIT];
  assign ded_hit_any = ded_five | ded_six | ded_seven;                          // [RULE13]

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always @* begin
    nxt_wake_flag_bits = wake_flag_bits_ff;
    if (wr_flags) begin
      // Writing 0 clears; a write of 1 leaves the bit as it is
      nxt_wake_flag_bits = wake_flag_bits_ff & reg_wdata_in[NUM_WAKE-1:0]; // [RULE16]
    end
    // An edge in the same cycle as the clear still lands
    nxt_wake_flag_bits = nxt_wake_flag_bits | wake_set;   // [RULE16] [RULE8]
  end

  // ----------------------------------------------------------------
  // Interrupt 0 pending request
  // ----------------------------------------------------------------
  always @* begin
    nxt_irq_zero_pend = irq_zero_pend_ff;
    if (wr_clear && (reg_wdata_in == `WUO_CLEAR_IRQ0_CODE)) begin
      nxt_irq_zero_pend = 1'b0;                            // [RULE17]
    end
    if (wake_mode) begin
      if (wake_any_set) begin
        nxt_irq_zero_pend = 1'b1;                          // [RULE4] [RULE6]
      end
    end else if (ext_rise) begin
      nxt_irq_zero_pend = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Event status
  // ----------------------------------------------------------------
  wire [`WUO_EVT_W-1:0] evt_now;
  assign evt_now[`WUO_EVT_WAKE_BIT] = wake_any_set;
  assign evt_now[`WUO_EVT_EXT0_BIT] = ~wake_mode & ext_rise;
  assign evt_now[`WUO_EVT_DED_BIT]  = ded_hit_any;
  assign evt_now[`WUO_EVT_OVL_BIT]  = |(wake_set & wake_flag_bits_ff);

  always @* begin
    nxt_evt_status = evt_status_ff;
    if (rd_evt_status) begin
      nxt_evt_status = {`WUO_EVT_W{1'b0}};
    end
    nxt_evt_status = nxt_evt_status | evt_now;
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always @* begin
    nxt_rdata = {`WUO_DATA_W{1'b0}};
    if (reg_addr_in == `WUO_OFS_WAKE_FLAGS) begin
      nxt_rdata = wake_flag_bits_ff;                       // [RULE8]
    end else if (reg_addr_in == `WUO_OFS_WAKE_MODE) begin
      nxt_rdata = wake_mode_bits_ff;
    end else if (reg_addr_in == `WUO_OFS_WAKE_EDGE) begin
      nxt_rdata = wake_edge_bits_ff;
    end else if (reg_addr_in == `WUO_OFS_WAKE_ENABLE) begin
      nxt_rdata = wake_enable_bits_ff;
    end else if (reg_addr_in == `WUO_OFS_IRQ_MASK0) begin
      nxt_rdata = irq_mask_group_zero_ff;
    end else if (reg_addr_in == `WUO_OFS_IRQ_PRIO0) begin
      nxt_rdata = {5'h00, irq_priority_zero_ff};
    end else if (reg_addr_in == `WUO_OFS_EVT_STATUS) begin
      nxt_rdata = {4'h0, evt_status_ff};
    end else if (reg_addr_in == `WUO_OFS_EVT_MASK) begin
      nxt_rdata = {4'h0, evt_mask_ff};
    end else if (reg_addr_in == `WUO_OFS_LINE_STATUS) begin
      nxt_rdata = {6'h00, wake_mode, irq_zero_pend_ff};
    end
  end

  // ----------------------------------------------------------------
  // Register updates
  // ----------------------------------------------------------------
  always @(posedge clock_in or negedge rstn_sync) begin
    if (!rstn_sync) begin
      wake_flag_bits_ff   <= `WUO_RST_WAKE;                // [RULE14]
      wake_mode_bits_ff   <= `WUO_RST_WAKE;                // [RULE14]
      wake_edge_bits_ff   <= `WUO_RST_WAKE;                // [RULE14]
      wake_enable_bits_ff <= `WUO_RST_WAKE;                // [RULE14]
    end else begin
      wake_flag_bits_ff <= nxt_wake_flag_bits;
      if (wr_mode) begin
        wake_mode_bits_ff <= reg_wdata_in[NUM_WAKE-1:0];   // [RULE9]
      end
      if (wr_edge) begin
        wake_edge_bits_ff <= reg_wdata_in[NUM_WAKE-1:0];   // [RULE10]
      end
      if (wr_enable) begin
        wake_enable_bits_ff <= reg_wdata_in[NUM_WAKE-1:0]; // [RULE3] [RULE7]
      end
    end
  end

  always @(posedge clock_in or negedge rstn_sync) begin
    if (!rstn_sync) begin
      irq_mask_group_zero_ff <= `WUO_RST_IRQ_MASK0;        // [RULE15]
      irq_priority_zero_ff   <= `WUO_RST_IRQ_PRIO0;
      evt_mask_ff            <= `WUO_RST_EVT;
    end else begin
      if (wr_mask0) begin
        irq_mask_group_zero_ff <= reg_wdata_in;            // [RULE15]
      end
      if (wr_prio) begin
        irq_priority_zero_ff <= reg_wdata_in[`WUO_PRIO_W-1:0];
      end
      if (wr_evt_mask) begin
        evt_mask_ff <= reg_wdata_in[`WUO_EVT_W-1:0];
      end
    end
  end

  always @(posedge clock_in or negedge rstn_sync) begin
    if (!rstn_sync) begin
      irq_zero_pend_ff <= 1'b0;
      evt_status_ff    <= `WUO_RST_EVT;
      rdata_ff         <= {`WUO_DATA_W{1'b0}};
      ext_prev_ff      <= 1'b0;
      ext_armed_ff     <= 1'b0;
    end else begin
      irq_zero_pend_ff <= nxt_irq_zero_pend;
      evt_status_ff    <= nxt_evt_status;
      // Read data stands only in the cycle after the strobe
      rdata_ff         <= reg_rd_in ? nxt_rdata : {`WUO_DATA_W{1'b0}};
      ext_prev_ff      <= ext_irq_zero_pin_in;             // [RULE12]
      ext_armed_ff     <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Output flops
  // ----------------------------------------------------------------
  // Level 0 counts as disabled, so a masked or unprioritised line never
  // reaches the core even with the request pending.
  always @(posedge clock_in or negedge rstn_sync) begin
    if (!rstn_sync) begin
      irq_zero_out_ff <= 1'b0;
      level_out_ff    <= `WUO_RST_IRQ_PRIO0;
      ded_five_ff     <= 1'b0;
      ded_six_ff      <= 1'b0;
      ded_seven_ff    <= 1'b0;
      standby_ff      <= 1'b0;
      wake_mode_ff    <= 1'b0;
      irq_ff          <= 1'b0;
    end else begin
      irq_zero_out_ff <= irq_zero_pend_ff
                         & irq_mask_group_zero_ff[`WUO_MASK0_IRQ0_BIT]
                         & (|irq_priority_zero_ff);        // [RULE5]
      level_out_ff    <= irq_priority_zero_ff;
      ded_five_ff     <= ded_five;                         // [RULE13]
      ded_six_ff      <= ded_six;                          // [RULE13]
      ded_seven_ff    <= ded_seven;                        // [RULE13]
      standby_ff      <= |(wake_flag_bits_ff & wake_enable_bits_ff); // [RULE1]
      wake_mode_ff    <= wake_mode;                        // [RULE6]
      irq_ff          <= |(nxt_evt_status & evt_mask_ff);
    end
  end

  // ----------------------------------------------------------------
  // Port drive
  // ----------------------------------------------------------------
  assign reg_rdata_out               = rdata_ff;
  assign shared_ext_irq_zero_out     = irq_zero_out_ff;
  assign irq_zero_level_out          = level_out_ff;
  assign dedicated_ext_irq_five_out  = ded_five_ff;
  assign dedicated_ext_irq_six_out   = ded_six_ff;
  assign dedicated_ext_irq_seven_out = ded_seven_ff;
  assign standby_release_out         = standby_ff;
  assign wake_mode_active_out        = wake_mode_ff;
  assign irq_out                     = irq_ff;

endmodule

// *** hw/wuo_regs.vh ***
// Register offsets, field positions and reset values of the wake-up on/off logic
`ifndef WUO_REGS_VH
`define WUO_REGS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses on the 8-bit register port)
// ----------------------------------------------------------------
`define WUO_ADDR_W           8
`define WUO_DATA_W           8
`define WUO_OFS_IRQ_MASK0    8'hE5
`define WUO_OFS_WAKE_FLAGS   8'hEC
`define WUO_OFS_WAKE_MODE    8'hED
`define WUO_OFS_WAKE_EDGE    8'hEE
`define WUO_OFS_WAKE_ENABLE  8'hEF
`define WUO_OFS_IRQ_PRIO0    8'hF0
`define WUO_OFS_IRQ_CLEAR    8'hF1
`define WUO_OFS_EVT_STATUS   8'hF2
`define WUO_OFS_EVT_MASK     8'hF3
`define WUO_OFS_LINE_STATUS  8'hF4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define WUO_RST_WAKE         8'h00
`define WUO_RST_IRQ_MASK0    8'hFF
`define WUO_RST_IRQ_PRIO0    3'h0
`define WUO_RST_EVT          4'h0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define WUO_MASK0_IRQ0_BIT   0
`define WUO_MASK0_IRQ5_BIT   5
`define WUO_MASK0_IRQ6_BIT   6
`define WUO_MASK0_IRQ7_BIT   7
`define WUO_PRIO_W           3
`define WUO_EVT_W            4
`define WUO_EVT_WAKE_BIT     0
`define WUO_EVT_EXT0_BIT     1
`define WUO_EVT_DED_BIT      2
`define WUO_EVT_OVL_BIT      3
`define WUO_CLEAR_IRQ0_CODE  8'h0A

// Pins that also carry a dedicated interrupt
`define WUO_PIN_IRQ5         0
`define WUO_PIN_IRQ6         1
`define WUO_PIN_IRQ7         4

`endif

// *** test/tb_top.sv ***
// Self-checking bench for the wake-up on/off interrupt block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NUM_WAKE = 8;
  logic       clock_in, rstn_in, reg_wr_in, reg_rd_in;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, pins;
  logic [2:0] lvl;
  logic       ext_pin, irq0, ded5, ded6, ded7, stby, wmode, irq_out;
  logic [7:0] five_cnt, six_cnt, seven_cnt;
  int         err_count, total_checks;
  logic [7:0] rst_addr [5] = '{8'hEC, 8'hED, 8'hEE, 8'hEF, 8'hE5};
  logic [7:0] rst_exp [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF};

  wuo_onoff #(.NUM_WAKE(NUM_WAKE)) i_wuo_onoff (
    .clock_in(clock_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .wake_pin_in(pins), .ext_irq_zero_pin_in(ext_pin),
    .shared_ext_irq_zero_out(irq0), .irq_zero_level_out(lvl),
    .dedicated_ext_irq_five_out(ded5), .dedicated_ext_irq_six_out(ded6),
    .dedicated_ext_irq_seven_out(ded7), .standby_release_out(stby),
    .wake_mode_active_out(wmode), .irq_out(irq_out));
  wuo_pin_src i_wuo_pin_src (.clock_in(clock_in), .pins_out(pins), .ext_pin_out(ext_pin));

  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  // Dedicated pulses last one cycle, so they are counted rather than sampled
  always @(posedge clock_in) begin
    five_cnt <= !rstn_in ? 8'h00 : five_cnt + {7'h00, ded5};
    six_cnt <= !rstn_in ? 8'h00 : six_cnt + {7'h00, ded6};
    seven_cnt <= !rstn_in ? 8'h00 : seven_cnt + {7'h00, ded7};
  end

  // ----------------------------------------------------------------
  // Bus and checking tasks
  // ----------------------------------------------------------------
  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic bit_chk(input string n, input logic v, input logic e);
    check(n, {7'h00, v}, {7'h00, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_wr_in <= 1'b1;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    #1;
    check(n, reg_rdata_out, e);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic cfg(input logic [7:0] md, input logic [7:0] ed, input logic [7:0] en);
    wr(8'hED, md);
    wr(8'hEE, ed);
    wr(8'hEF, en);
  endtask
  task automatic pin_step(input int p, input logic v, input logic [7:0] e);
    i_wuo_pin_src.set_pin(p, v);
    wait_cyc(4);
    rd_chk(8'hEC, e, "wake flags");
    wr(8'hEC, 8'h00);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock_in);
    err_count++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn_in = 1'b0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    repeat (6) @(posedge clock_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    for (int i = 0; i < 5; i++) rd_chk(rst_addr[i], rst_exp[i], "reset value");
    rd_chk(8'h10, 8'h00, "unmapped read");
    cfg(8'hA5, 8'h3C, 8'h00);
    rd_chk(8'hED, 8'hA5, "mode readback");
    rd_chk(8'hEE, 8'h3C, "edge readback");
    // Both-edge, both-edge with polarity set, falling only, rising only
    for (int c = 0; c < 4; c++) begin
      cfg({8{c[1]}}, {8{c[0]}}, 8'hFF);
      wr(8'hEC, 8'h00);
      pin_step(2, 1'b1, (!c[1] || c[0]) ? 8'h04 : 8'h00);
      pin_step(2, 1'b0, (!c[1] || !c[0]) ? 8'h04 : 8'h00);
    end
    cfg(8'h00, 8'h00, 8'hFB);
    pin_step(2, 1'b1, 8'h00);
    bit_chk("standby masked", stby, 1'b0);
    wr(8'hE5, 8'hFE);
    cfg(8'h13, 8'h13, 8'h11);
    wr(8'hF0, 8'h03);
    wr(8'hF1, 8'h0A);
    wait_cyc(3);
    wr(8'hE5, 8'hFF);
    i_wuo_pin_src.set_pin(0, 1'b1);
    wait_cyc(4);
    bit_chk("irq0 request", irq0, 1'b1);
    bit_chk("standby release", stby, 1'b1);
    bit_chk("wake mode", wmode, 1'b1);
    check("irq0 level", {5'h00, lvl}, 8'h03);
    check("irq5 pulses", five_cnt, 8'h01);
    wr(8'hE5, 8'hFE);
    wait_cyc(3);
    bit_chk("irq0 masked", irq0, 1'b0);
    wr(8'hE5, 8'hFF);
    wait_cyc(3);
    bit_chk("irq0 unmasked", irq0, 1'b1);
    wr(8'hF0, 8'h00);
    wait_cyc(3);
    bit_chk("irq0 level zero", irq0, 1'b0);
    wr(8'hF0, 8'h03);
    wr(8'hEC, 8'h00);
    wait_cyc(3);
    bit_chk("standby after clear", stby, 1'b0);
    wr(8'hF1, 8'h0A);
    wait_cyc(3);
    bit_chk("irq0 cleared", irq0, 1'b0);
    pin_step(4, 1'b1, 8'h10);
    check("irq7 pulses", seven_cnt, 8'h01);
    pin_step(1, 1'b1, 8'h00);
    check("irq6 pulses", six_cnt, 8'h01);
    wr(8'hF1, 8'h0A);
    i_wuo_pin_src.set_ext(1'b1);
    wait_cyc(4);
    bit_chk("ext pin ignored", irq0, 1'b0);
    i_wuo_pin_src.set_ext(1'b0);
    wr(8'hEF, 8'h00);
    wr(8'hF1, 8'h0A);
    wait_cyc(3);
    bit_chk("wake mode off", wmode, 1'b0);
    i_wuo_pin_src.set_ext(1'b1);
    wait_cyc(4);
    bit_chk("ext pin used", irq0, 1'b1);
    rd_chk(8'hF4, 8'h01, "line status");
    rd_chk(8'hF2, 8'h07, "event status");
    cfg(8'h00, 8'h00, 8'h08);
    i_wuo_pin_src.set_pin(3, 1'b1);
    wait_cyc(4);
    bit_chk("irq masked", irq_out, 1'b0);
    wr(8'hF3, 8'h01);
    wait_cyc(3);
    bit_chk("irq raised", irq_out, 1'b1);
    rd_chk(8'hF2, 8'h01, "event status");
    wait_cyc(2);
    bit_chk("irq cleared", irq_out, 1'b0);
    i_wuo_pin_src.set_pin(3, 1'b0);
    wait_cyc(4);
    rd_chk(8'hF2, 8'h09, "event overrun");
    stop_test();
  end
endmodule

bind wuo_onoff wuo_onoff_chk #(.NUM_WAKE(NUM_WAKE)) i_wuo_onoff_chk (
  .clock_in(clock_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .wake_pin_in(wake_pin_in),
  .ext_irq_zero_pin_in(ext_irq_zero_pin_in), .shared_ext_irq_zero_out(shared_ext_irq_zero_out),
  .irq_zero_level_out(irq_zero_level_out), .dedicated_ext_irq_five_out(dedicated_ext_irq_five_out),
  .dedicated_ext_irq_six_out(dedicated_ext_irq_six_out),
  .dedicated_ext_irq_seven_out(dedicated_ext_irq_seven_out),
  .standby_release_out(standby_release_out), .wake_mode_active_out(wake_mode_active_out),
  .irq_out(irq_out));

// *** test/wuo_onoff_assertions.sv ***
// Port-level concurrent checks for the wake-up on/off interrupt block
`include "wuo_regs.vh"

module wuo_onoff_chk #(
  parameter NUM_WAKE = 8
) (
  input wire logic                   clock_in,
  input wire logic                   rstn_in,
  input wire logic [`WUO_ADDR_W-1:0] reg_addr_in,
  input wire logic [`WUO_DATA_W-1:0] reg_wdata_in,
  input wire logic                   reg_wr_in,
  input wire logic                   reg_rd_in,
  input wire logic [`WUO_DATA_W-1:0] reg_rdata_out,
  input wire logic [NUM_WAKE-1:0]    wake_pin_in,
  input wire logic                   ext_irq_zero_pin_in,
  input wire logic                   shared_ext_irq_zero_out,
  input wire logic [`WUO_PRIO_W-1:0] irq_zero_level_out,
  input wire logic                   dedicated_ext_irq_five_out,
  input wire logic                   dedicated_ext_irq_six_out,
  input wire logic                   dedicated_ext_irq_seven_out,
  input wire logic                   standby_release_out,
  input wire logic                   wake_mode_active_out,
  input wire logic                   irq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic mapped = (reg_addr_in == 8'hE5) || (reg_addr_in >= 8'hEC && reg_addr_in <= 8'hF4);
  wire logic en_wr = reg_wr_in && reg_addr_in == 8'hEF;

  default clocking @(posedge clock_in);
  endclocking
  default disable iff (!rstn_in);

  a_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data not zero outside the read slot");
  a_unmapped_read: assert property (reg_rd_in && !mapped |=> reg_rdata_out == 8'h00)
    else $error("unmapped read returned data");
  a_mode_on: assert property (en_wr && reg_wdata_in != 8'h00 |-> ##[1:3] wake_mode_active_out)
    else $error("wake mode not entered after enable write");
  a_mode_off: assert property (en_wr && reg_wdata_in == 8'h00 |-> ##[1:3] !wake_mode_active_out)
    else $error("wake mode not left after zero enable write");
  a_standby_mode: assert property (standby_release_out |-> wake_mode_active_out
    || $past(wake_mode_active_out))
    else $error("standby release without any enabled input");
  a_irq0_level: assert property (shared_ext_irq_zero_out |-> irq_zero_level_out != 3'h0
    || $past(irq_zero_level_out) != 3'h0)
    else $error("interrupt 0 request with priority zero");
  a_five_origin: assert property (dedicated_ext_irq_five_out |-> $past(wake_pin_in[0])
    || $past(wake_pin_in[0], 2))
    else $error("interrupt 5 pulse without high pin");
  a_six_origin: assert property (dedicated_ext_irq_six_out |-> $past(wake_pin_in[1])
    || $past(wake_pin_in[1], 2))
    else $error("interrupt 6 pulse without high pin");
  a_seven_pulse: assert property (dedicated_ext_irq_seven_out |=> !dedicated_ext_irq_seven_out)
    else $error("interrupt 7 pulse longer than one cycle");

  c_standby: cover property ($rose(standby_release_out));
  c_irq0: cover property ($rose(shared_ext_irq_zero_out));
  c_five: cover property (dedicated_ext_irq_five_out);
endmodule

// *** test/wuo_pin_src.sv ***
// Far-side model: sources that drive the port pin levels and the interrupt 0 pin
module wuo_pin_src (
  // Clock
  input  wire logic       clock_in,
  // Pin levels
  output logic      [7:0] pins_out,
  output logic            ext_pin_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    pins_out = 8'h00;
    ext_pin_out = 1'b0;
  end
  // Pins carry a real driven level whatever function the port has
  task automatic set_pin(input int idx, input logic val);
    @(posedge clock_in);
    pins_out[idx] <= val;
  endtask
  task automatic set_ext(input logic val);
    @(posedge clock_in);
    ext_pin_out <= val;
  endtask
endmodule
